// ### fpc_pkg.sv
package fpc_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_KEY    = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_MASK   = 8'h0C;
  localparam logic [7:0] ADDR_DYNCFG = 8'h10;
  // ==========================================================
  // Control register fields
  localparam int BIT_START  = 15;
  localparam int BIT_FLASH_WRITE_ENABLE   = 14;
  localparam int BIT_SEQERR = 13;
  localparam int BIT_LVERR  = 12;
  localparam int BIT_SWAP   = 7;
  localparam int OP_LSB     = 0;
  localparam int OP_W       = 4;
  // ==========================================================
  // Unlock keys, operation codes and ECC setting
  localparam logic [31:0] KEY1 = 32'hAA99_6655;
  localparam logic [31:0] KEY2 = 32'h5566_99AA;
  localparam logic [3:0]  OP_CLEAR_ERR = 4'h0;
  localparam logic [3:0]  OP_NO_ECC    = 4'h1;
  localparam logic [1:0]  ECC_ALWAYS   = 2'h0;
  // ==========================================================
  // Interrupt status bits, bus response codes and engine states
  localparam int IRQ_DONE   = 0;
  localparam int IRQ_SEQERR = 1;
  localparam int IRQ_LVERR  = 2;
  localparam int IRQ_W      = 3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    FPC_IDLE = 2'b00,
    FPC_RUN  = 2'b01,
    FPC_DONE = 2'b10
  } fpc_op_state_t;
endpackage

// ### fpc_op_engine.sv
`timescale 1ns/1ps
// ==========================================================
// Operation engine: starts the flash array, waits for its done
module fpc_op_engine (
  input  wire logic       REF_CLK_IN,
  input  wire logic       SRST_IN,
  input  wire logic       launch_in,
  input  wire logic [3:0] op_in,
  input  wire logic [1:0] ecc_cfg_in,
  input  wire logic       flash_done_in,
  input  wire logic       flash_fail_in,
  input  wire logic       flash_lowv_in,
  output logic            flash_req_out,
  output logic [3:0]      flash_op_out,
  output logic            busy_out,
  output logic            done_out,
  output logic            fail_out,
  output logic            lowv_out
);
  typedef struct packed {
    fpc_pkg::fpc_op_state_t st;
    logic [3:0]             op;
    logic                   lowv;
  } fpc_eng_t;
  fpc_eng_t s_r;
  fpc_eng_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    done_out = 1'b0;
    fail_out = 1'b0;
    lowv_out = 1'b0;
    unique case (s_r.st)
      fpc_pkg::FPC_IDLE: begin
        if (launch_in) begin
          s_nxt.op = op_in;
          s_nxt.lowv = 1'b0;
          // No-ECC write is a no-op while ECC is forced on
          if (op_in == fpc_pkg::OP_NO_ECC && ecc_cfg_in == fpc_pkg::ECC_ALWAYS) begin
            s_nxt.st = fpc_pkg::FPC_DONE;
          end else begin
            s_nxt.st = fpc_pkg::FPC_RUN;
          end
        end
      end
      fpc_pkg::FPC_RUN: begin
        if (flash_lowv_in) begin
          s_nxt.lowv = 1'b1;
        end
        if (flash_done_in) begin
          s_nxt.st = fpc_pkg::FPC_IDLE;
          done_out = 1'b1;
          fail_out = flash_fail_in;
          lowv_out = s_r.lowv | flash_lowv_in;
        end
      end
      fpc_pkg::FPC_DONE: begin
        s_nxt.st = fpc_pkg::FPC_IDLE;
        done_out = 1'b1;
      end
      default: s_nxt.st = fpc_pkg::FPC_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      s_r <= '{st: fpc_pkg::FPC_IDLE, op: 4'h0, lowv: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign flash_req_out = (s_r.st == fpc_pkg::FPC_RUN);
  assign flash_op_out  = s_r.op;
  assign busy_out      = (s_r.st != fpc_pkg::FPC_IDLE);
endmodule

// ### fpc_top.sv
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module fpc_top (
  input  wire logic        REF_CLK_IN,
  input  wire logic        SRST_IN,
  input  wire logic        POR_IN,
  input  wire logic [7:0]  S_AXI_AWADDR_IN,
  input  wire logic        S_AXI_AWVALID_IN,
  output logic             S_AXI_AWREADY_OUT,
  input  wire logic [31:0] S_AXI_WDATA_IN,
  input  wire logic [3:0]  S_AXI_WSTRB_IN,
  input  wire logic        S_AXI_WVALID_IN,
  output logic             S_AXI_WREADY_OUT,
  output logic [1:0]       S_AXI_BRESP_OUT,
  output logic             S_AXI_BVALID_OUT,
  input  wire logic        S_AXI_BREADY_IN,
  input  wire logic [7:0]  S_AXI_ARADDR_IN,
  input  wire logic        S_AXI_ARVALID_IN,
  output logic             S_AXI_ARREADY_OUT,
  output logic [31:0]      S_AXI_RDATA_OUT,
  output logic [1:0]       S_AXI_RRESP_OUT,
  output logic             S_AXI_RVALID_OUT,
  input  wire logic        S_AXI_RREADY_IN,
  input  wire logic        FLASH_DONE_IN,
  input  wire logic        FLASH_FAIL_IN,
  input  wire logic        FLASH_LOWV_IN,
  output logic             FLASH_REQ_OUT,
  output logic [3:0]       FLASH_OP_OUT,
  output logic             BANK_LOWER_IS_2_OUT,
  output logic             BANK_UPPER_IS_2_OUT,
  output logic             IRQ_OUT
);
  // ==========================================================
  // State
  typedef struct packed {
    logic                    aw_got;
    logic [7:0]              aw_addr;
    logic                    w_got;
    logic [31:0]             w_data;
    logic [3:0]              w_strb;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    rvalid;
    logic [31:0]             rdata;
    logic [1:0]              rresp;
    logic                    key1_seen;
    logic                    unlocked;
    logic                    swap;
    logic [3:0]              op;
    logic [1:0]              ecc_cfg;
    logic [2:0]              irq_sts;
    logic [2:0]              irq_mask;
  } fpc_regs_t;
  typedef struct packed {
    logic start;
    logic flash_write_enable;
    logic seqerr;
    logic lverr;
  } fpc_por_t;

  fpc_regs_t s_r;
  fpc_regs_t s_nxt;
  fpc_por_t  p_r;
  fpc_por_t  p_nxt;

  logic       launch;
  logic       eng_busy;
  logic       eng_done;
  logic       eng_fail;
  logic       eng_lowv;
  logic       wr_fire;
  logic       guarded_wr;
  logic [31:0] ctrl_view;

  function automatic logic [31:0] ctrl_word(input fpc_por_t p, input logic sw, input logic [3:0] op);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[fpc_pkg::BIT_START]  = p.start;
    v[fpc_pkg::BIT_FLASH_WRITE_ENABLE]   = p.flash_write_enable;
    v[fpc_pkg::BIT_SEQERR] = p.seqerr;
    v[fpc_pkg::BIT_LVERR]  = p.lverr;
    v[fpc_pkg::BIT_SWAP]   = sw;
    v[fpc_pkg::OP_LSB +: fpc_pkg::OP_W] = op;
    return v;
  endfunction

  assign ctrl_view = ctrl_word(p_r, s_r.swap, s_r.op);

  // ==========================================================
  // Bus write and register update
  always_comb begin
    s_nxt = s_r;
    p_nxt = p_r;
    launch = 1'b0;
    guarded_wr = 1'b0;
    wr_fire = s_r.aw_got && s_r.w_got && !s_r.bvalid;
    if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.aw_addr = S_AXI_AWADDR_IN;
    end
    if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
      s_nxt.w_got = 1'b1;
      s_nxt.w_data = S_AXI_WDATA_IN;
      s_nxt.w_strb = S_AXI_WSTRB_IN;
    end
    if (s_r.bvalid && S_AXI_BREADY_IN) begin
      s_nxt.bvalid = 1'b0;
    end
    if (wr_fire) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = fpc_pkg::RESP_OKAY;
      // Any write other than the second key breaks the unlock pair
      s_nxt.key1_seen = 1'b0;
      unique case (s_r.aw_addr)
        fpc_pkg::ADDR_CTRL: begin
          if (s_r.w_strb[1]) begin
            p_nxt.flash_write_enable = s_r.w_data[fpc_pkg::BIT_FLASH_WRITE_ENABLE];
            if (p_r.flash_write_enable && s_r.unlocked && s_r.w_data[fpc_pkg::BIT_START] && !p_r.start) begin
              p_nxt.start = 1'b1;
              launch = 1'b1;
              guarded_wr = 1'b1;
            end
          end
          if (s_r.w_strb[0]) begin
            if (!p_r.flash_write_enable) begin
              s_nxt.op = s_r.w_data[fpc_pkg::OP_LSB +: fpc_pkg::OP_W];
              if (s_r.unlocked && s_r.w_data[fpc_pkg::BIT_SWAP] != s_r.swap) begin
                s_nxt.swap = s_r.w_data[fpc_pkg::BIT_SWAP];
                guarded_wr = 1'b1;
              end
            end
          end
        end
        fpc_pkg::ADDR_KEY: begin
          if (s_r.w_data == fpc_pkg::KEY1) begin
            s_nxt.key1_seen = 1'b1;
          end else if (s_r.key1_seen && s_r.w_data == fpc_pkg::KEY2) begin
            s_nxt.unlocked = 1'b1;
          end
        end
        fpc_pkg::ADDR_STATUS: begin
          s_nxt.irq_sts = s_r.irq_sts & ~s_r.w_data[fpc_pkg::IRQ_W-1:0];
        end
        fpc_pkg::ADDR_MASK: begin
          s_nxt.irq_mask = s_r.w_data[fpc_pkg::IRQ_W-1:0];
        end
        fpc_pkg::ADDR_DYNCFG: begin
          s_nxt.ecc_cfg = s_r.w_data[1:0];
        end
        default: s_nxt.bresp = fpc_pkg::RESP_SLVERR;
      endcase
      if (guarded_wr) begin
        s_nxt.unlocked = 1'b0;
      end
    end
    // Operation completion: start drops, errors update, status sets win over clears
    if (eng_done) begin
      p_nxt.start = 1'b0;
      // Latched code, so a system reset in flight cannot turn a run into a clear
      if (FLASH_OP_OUT == fpc_pkg::OP_CLEAR_ERR) begin
        p_nxt.seqerr = 1'b0;
        p_nxt.lverr = 1'b0;
      end
      if (eng_fail) begin
        p_nxt.seqerr = 1'b1;
      end
      if (eng_lowv) begin
        p_nxt.lverr = 1'b1;
      end
      s_nxt.irq_sts[fpc_pkg::IRQ_DONE] = 1'b1;
      s_nxt.irq_sts[fpc_pkg::IRQ_SEQERR] = s_nxt.irq_sts[fpc_pkg::IRQ_SEQERR] | eng_fail;
      s_nxt.irq_sts[fpc_pkg::IRQ_LVERR] = s_nxt.irq_sts[fpc_pkg::IRQ_LVERR] | eng_lowv;
    end
    // ==========================================================
    // Bus read
    if (s_r.rvalid && S_AXI_RREADY_IN) begin
      s_nxt.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = fpc_pkg::RESP_OKAY;
      unique case (S_AXI_ARADDR_IN)
        fpc_pkg::ADDR_CTRL:   s_nxt.rdata = ctrl_view;
        fpc_pkg::ADDR_KEY:    s_nxt.rdata = 32'h0000_0000;
        fpc_pkg::ADDR_STATUS: s_nxt.rdata = {29'h0000_0000, s_r.irq_sts};
        fpc_pkg::ADDR_MASK:   s_nxt.rdata = {29'h0000_0000, s_r.irq_mask};
        fpc_pkg::ADDR_DYNCFG: s_nxt.rdata = {30'h0000_0000, s_r.ecc_cfg};
        default: begin
          s_nxt.rdata = 32'h0000_0000;
          s_nxt.rresp = fpc_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // ==========================================================
  // Registers: bus-side state on system reset, flash flags on power-on only
  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (POR_IN) begin
      p_r <= '0;
    end else begin
      p_r <= p_nxt;
    end
  end

  fpc_op_engine u_eng (
    .REF_CLK_IN    (REF_CLK_IN),
    .SRST_IN       (POR_IN),
    .launch_in     (launch),
    .op_in         (s_r.op),
    .ecc_cfg_in    (s_r.ecc_cfg),
    .flash_done_in (FLASH_DONE_IN),
    .flash_fail_in (FLASH_FAIL_IN),
    .flash_lowv_in (FLASH_LOWV_IN),
    .flash_req_out (FLASH_REQ_OUT),
    .flash_op_out  (FLASH_OP_OUT),
    .busy_out      (eng_busy),
    .done_out      (eng_done),
    .fail_out      (eng_fail),
    .lowv_out      (eng_lowv)
  );

  assign S_AXI_AWREADY_OUT = !s_r.aw_got && !s_r.bvalid;
  assign S_AXI_WREADY_OUT  = !s_r.w_got && !s_r.bvalid;
  assign S_AXI_BVALID_OUT  = s_r.bvalid;
  assign S_AXI_BRESP_OUT   = s_r.bresp;
  assign S_AXI_ARREADY_OUT = !s_r.rvalid;
  assign S_AXI_RVALID_OUT  = s_r.rvalid;
  assign S_AXI_RDATA_OUT   = s_r.rdata;
  assign S_AXI_RRESP_OUT   = s_r.rresp;
  assign BANK_LOWER_IS_2_OUT = s_r.swap;
  assign BANK_UPPER_IS_2_OUT = !s_r.swap;
  assign IRQ_OUT = |(s_r.irq_sts & s_r.irq_mask);

  // ==========================================================
  // Checks
  AST_START_NEEDS_UNLOCK: assert property (@(posedge REF_CLK_IN) disable iff (POR_IN || SRST_IN)
    $rose(p_r.start) |-> $past(p_r.flash_write_enable) && $past(s_r.unlocked))
    else $error("start set without write-enable and unlock");
  AST_START_LAUNCHES: assert property (@(posedge REF_CLK_IN) disable iff (POR_IN || SRST_IN)
    launch && !(s_r.op == fpc_pkg::OP_NO_ECC && s_r.ecc_cfg == fpc_pkg::ECC_ALWAYS) |=> FLASH_REQ_OUT)
    else $error("start did not launch operation");
  AST_START_IDLE_ZERO: assert property (@(posedge REF_CLK_IN) disable iff (POR_IN || SRST_IN)
    !eng_busy && !launch |=> !p_r.start || eng_busy)
    else $error("start set while idle");
  AST_OP_FROZEN: assert property (@(posedge REF_CLK_IN) disable iff (POR_IN || SRST_IN)
    p_r.flash_write_enable && !SRST_IN |=> $stable(s_r.op))
    else $error("selector changed while write-enable set");
  AST_SEQERR_SET: assert property (@(posedge REF_CLK_IN) disable iff (POR_IN || SRST_IN)
    eng_done && eng_fail |=> p_r.seqerr)
    else $error("sequence error not set on failure");
  AST_LVERR_HOLD: assert property (@(posedge REF_CLK_IN) disable iff (POR_IN || SRST_IN)
    p_r.lverr && !(eng_done && FLASH_OP_OUT == fpc_pkg::OP_CLEAR_ERR) |=> p_r.lverr)
    else $error("low-voltage error cleared wrongly");
  AST_SWAP_GUARD: assert property (@(posedge REF_CLK_IN) disable iff (POR_IN || SRST_IN)
    $changed(s_r.swap) && !$past(SRST_IN) |-> $past(!p_r.flash_write_enable) && $past(s_r.unlocked))
    else $error("swap changed without guard");
  AST_NOECC_NOP: assert property (@(posedge REF_CLK_IN) disable iff (POR_IN || SRST_IN)
    launch && s_r.op == fpc_pkg::OP_NO_ECC && s_r.ecc_cfg == fpc_pkg::ECC_ALWAYS |=> !FLASH_REQ_OUT ##1 !p_r.start)
    else $error("no-ECC operation ran while ECC forced on");
  AST_RSVD_ZERO: assert property (@(posedge REF_CLK_IN) disable iff (POR_IN || SRST_IN)
    ctrl_view[11:8] == 4'h0 && ctrl_view[6:4] == 3'h0)
    else $error("reserved control bits not zero");

  // ==========================================================
  // Checks on start, error flags and unlock
  AST_START_HW_CLEAR: assert property (@(posedge REF_CLK_IN) disable iff (POR_IN || SRST_IN)
    $fell(p_r.start) && !$past(POR_IN) |-> $past(eng_done))
    else $error("start cleared without operation completion");
  AST_REQ_NEEDS_START: assert property (@(posedge REF_CLK_IN) disable iff (POR_IN || SRST_IN)
    FLASH_REQ_OUT |-> p_r.start)
    else $error("flash request without start bit");
  AST_SEQERR_HOLD: assert property (@(posedge REF_CLK_IN) disable iff (POR_IN || SRST_IN)
    p_r.seqerr && !(eng_done && FLASH_OP_OUT == fpc_pkg::OP_CLEAR_ERR) |=> p_r.seqerr)
    else $error("sequence error cleared wrongly");
  AST_ERR_CLEAR: assert property (@(posedge REF_CLK_IN) disable iff (POR_IN || SRST_IN)
    eng_done && FLASH_OP_OUT == fpc_pkg::OP_CLEAR_ERR && !eng_fail |=> !p_r.seqerr)
    else $error("clear operation left sequence error set");
  AST_LVERR_SET: assert property (@(posedge REF_CLK_IN) disable iff (POR_IN || SRST_IN)
    eng_done && eng_lowv |=> p_r.lverr)
    else $error("low-voltage error not set on low supply");
  AST_UNLOCK_SPENT: assert property (@(posedge REF_CLK_IN) disable iff (POR_IN || SRST_IN)
    launch |=> !s_r.unlocked)
    else $error("unlock not spent by start");
endmodule

// ### fpc_flash_model.sv
`timescale 1ns/1ps
// ==========================================================
// Flash array stand-in: answers each request after a set delay
module fpc_flash_model (
  input  wire logic       clk_in,
  input  wire logic       req_in,
  input  wire logic [7:0] delay_in,
  input  wire logic       fail_cfg_in,
  input  wire logic       lowv_cfg_in,
  output logic            done_out,
  output logic            fail_out,
  output logic            lowv_out
);
  logic [7:0] cnt_r;
  always_ff @(posedge clk_in) begin
    cnt_r <= req_in ? cnt_r + 8'h01 : 8'h00;
  end
  // Done is one cycle wide; fail is only meaningful beside it
  assign done_out = req_in && (cnt_r == delay_in);
  assign fail_out = done_out ? fail_cfg_in : ~fail_cfg_in;
  assign lowv_out = req_in && lowv_cfg_in;
endmodule

// ### tb.sv
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0, srst = 1'b1, por = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic fcfg = 1'b0, lcfg = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, fdone, ffail, flowv, freq, blow, bup, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [3:0] fop;
  int bad_count = 0, n_tests = 0, req_cnt = 0, r0;
  logic [31:0] d;
  logic [1:0] r;
  localparam logic [31:0] WE = 32'h0000_4000, GO = 32'h0000_8000, SE = 32'h0000_2000;
  localparam logic [31:0] LE = 32'h0000_1000, SW = 32'h0000_0080;
  always #12.5 clk = ~clk;
  always @(posedge clk) if (freq === 1'b1) req_cnt++;
  fpc_top DUT (.REF_CLK_IN(clk), .SRST_IN(srst), .POR_IN(por),
    .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
    .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready),
    .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
    .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready),
    .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready),
    .FLASH_DONE_IN(fdone), .FLASH_FAIL_IN(ffail), .FLASH_LOWV_IN(flowv), .FLASH_REQ_OUT(freq),
    .FLASH_OP_OUT(fop), .BANK_LOWER_IS_2_OUT(blow), .BANK_UPPER_IS_2_OUT(bup), .IRQ_OUT(irq));
  fpc_flash_model FM (.clk_in(clk), .req_in(freq), .delay_in(8'h14), .fail_cfg_in(fcfg),
    .lowv_cfg_in(lcfg), .done_out(fdone), .fail_out(ffail), .lowv_out(flowv));
  // ==========================================================
  // Checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("tests %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ==========================================================
  // AXI4-Lite master
  task automatic wr(input logic [7:0] a, input logic [31:0] dd, output logic [1:0] rs);
    logic ad, wd, ta, tw;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge clk);
    awaddr <= a; wdata <= dd; awvalid <= 1'b1; wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge clk);
      if (ta) begin awvalid <= 1'b0; ad = 1'b1; end
      if (tw) begin wvalid <= 1'b0; wd = 1'b1; end
    end
    bready <= 1'b1;
    do @(negedge clk); while (bvalid !== 1'b1);
    rs = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] dd, output logic [1:0] rs);
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1;
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 1'b0; rready <= 1'b1;
    do @(negedge clk); while (rvalid !== 1'b1);
    dd = rdata;
    rs = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] dd);
    logic [1:0] rs;
    wr(a, dd, rs);
  endtask
  task automatic wc(input logic [31:0] dd);
    w(fpc_pkg::ADDR_CTRL, dd);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] dd;
    logic [1:0] rs;
    rd(a, dd, rs);
    chk(dd, e);
  endtask
  task automatic unlock();
    w(fpc_pkg::ADDR_KEY, fpc_pkg::KEY1);
    w(fpc_pkg::ADDR_KEY, fpc_pkg::KEY2);
  endtask
  // Selects op, arms, unlocks, starts, then polls until start drops
  task automatic run(input logic [3:0] op, input logic f, input logic l);
    logic [31:0] dd;
    logic [1:0] rs;
    int k;
    @(posedge clk);
    fcfg <= f; lcfg <= l;
    wc(32'h0);
    wc(32'(op));
    wc(WE | 32'(op));
    unlock();
    wc(WE | GO | 32'(op));
    k = 0;
    do begin rd(fpc_pkg::ADDR_CTRL, dd, rs); k++; end while (dd[15] !== 1'b0 && k < 40);
    chk(32'(dd[15]), 32'h0);
  endtask
  // ==========================================================
  // Tests
  initial begin
    #500_000;
    bad_count++;
    test_done();
  end
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0; por <= 1'b0;
    rc(fpc_pkg::ADDR_CTRL, 32'h0);
    chk({30'h0, blow, bup}, 32'h1);
    wc(WE); wc(WE | GO);
    rc(fpc_pkg::ADDR_CTRL, WE);
    wc(WE | 32'h3);
    rc(fpc_pkg::ADDR_CTRL, WE);
    wc(32'h0); wc(32'h3); wc(WE | 32'h3); wc(WE | 32'h5);
    rc(fpc_pkg::ADDR_CTRL, WE | 32'h3);
    w(fpc_pkg::ADDR_KEY, fpc_pkg::KEY1); w(fpc_pkg::ADDR_MASK, 32'h0); w(fpc_pkg::ADDR_KEY, fpc_pkg::KEY2);
    wc(WE | GO | 32'h3);
    @(negedge clk);
    chk(32'(freq), 32'h0);
    @(posedge clk);
    fcfg <= 1'b1;
    unlock();
    wc(WE | GO | 32'h3);
    @(negedge clk);
    chk({27'h0, freq, fop}, 32'h13);
    rc(fpc_pkg::ADDR_CTRL, WE | GO | 32'h3);
    repeat (25) @(posedge clk);
    rc(fpc_pkg::ADDR_CTRL, WE | SE | 32'h3);
    wc(WE | GO | 32'h3);
    rc(fpc_pkg::ADDR_CTRL, WE | SE | 32'h3);
    rc(fpc_pkg::ADDR_STATUS, 32'h3);
    chk(32'(irq), 32'h0);
    w(fpc_pkg::ADDR_MASK, 32'h2);
    @(negedge clk);
    chk(32'(irq), 32'h1);
    w(fpc_pkg::ADDR_STATUS, 32'h2);
    @(negedge clk);
    chk(32'(irq), 32'h0);
    rc(fpc_pkg::ADDR_STATUS, 32'h1);
    run(4'h2, 1'b0, 1'b1);
    rc(fpc_pkg::ADDR_CTRL, WE | SE | LE | 32'h2);
    @(posedge clk) srst <= 1'b1;
    @(posedge clk) srst <= 1'b0;
    rc(fpc_pkg::ADDR_CTRL, WE | SE | LE);
    run(4'h0, 1'b0, 1'b0);
    rc(fpc_pkg::ADDR_CTRL, WE);
    r0 = req_cnt;
    run(4'h1, 1'b0, 1'b0);
    chk(32'(req_cnt), 32'(r0));
    w(fpc_pkg::ADDR_DYNCFG, 32'h1);
    run(4'h1, 1'b0, 1'b0);
    chk(32'(req_cnt > r0), 32'h1);
    unlock(); wc(WE | SW);
    @(negedge clk);
    chk(32'(blow), 32'h0);
    wc(32'h0); unlock(); wc(SW);
    @(negedge clk);
    chk({30'h0, blow, bup}, 32'h2);
    wc(32'hFFFF_0F70);
    rc(fpc_pkg::ADDR_CTRL, SW);
    wr(8'h20, 32'h1, r);
    chk(32'(r), 32'(fpc_pkg::RESP_SLVERR));
    rd(8'h20, d, r);
    chk(32'(r), 32'(fpc_pkg::RESP_SLVERR));
    wc(WE | SW);
    @(posedge clk) por <= 1'b1;
    @(posedge clk) por <= 1'b0;
    rc(fpc_pkg::ADDR_CTRL, SW);
    test_done();
  end
endmodule
